/* design/asc_params.svh */
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

`define ASC_CONV_CYCLES   5'h10
`define ASC_CTL_BITS      4'h8
`define ASC_ADDR_MSB      5
`define ASC_ADDR_LSB      3
`define ASC_TRACK_LAST    4'h3
`define ASC_LOAD_EDGE     4'h4
`define ASC_DATA_FIRST    4'h5
`define ASC_DATA_LAST     4'hE
`define ASC_EDGE_LAST     4'h0
`define ASC_EDGE_FIRST    4'h1
`define ASC_CHAN_RESET    3'h0
`define ASC_CODE_RESET    10'h000
`define ASC_CTL_RESET     8'h00
`define ASC_BUF_DEPTH     2'h2

`endif

/* design/asc_pkg.sv */
package asc_pkg;

  typedef logic [2:0] asc_chan_t;
  typedef logic [9:0] asc_code_t;

  typedef struct packed {
    asc_chan_t channel;
    asc_code_t code;
  } asc_sample_t;

  typedef enum logic [1:0] {
    ASC_IDLE = 2'b01,
    ASC_WAIT = 2'b10
  } asc_hs_state_t;

endpackage

/* design/asc_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module asc_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output var  logic q
);
  logic meta;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

/* design/asc_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"
module asc_buf2 (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 in_valid,
  output var  logic                 in_ready,
  input  wire asc_pkg::asc_sample_t in_data,
  output var  logic                 out_valid,
  input  wire logic                 out_ready,
  output var  asc_pkg::asc_sample_t out_data
);
  import asc_pkg::*;

  asc_sample_t mem [2];
  logic        wr_ptr;
  logic        rd_ptr;
  logic [1:0]  count;
  logic [1:0]  next_count;
  logic        push;
  logic        pop;

  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 2'h1;
    else if (pop && !push)
      next_count = count - 2'h1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count     <= 2'h0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end
    else
    begin
      count     <= next_count;
      in_ready  <= (next_count != `ASC_BUF_DEPTH);
      out_valid <= (next_count != 2'h0);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      mem[0] <= '0;
      mem[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
    end
  end

  property p_full_stalls;
    @(posedge clk) disable iff (!rst_n)
    (count == `ASC_BUF_DEPTH) |-> !in_ready;
  endproperty
  a_full_stalls: assert property (p_full_stalls)
    else $error("buffer full but still ready");

  property p_valid_follows_fill;
    @(posedge clk) disable iff (!rst_n)
    push && (count == 2'h0) |=> out_valid && (out_data == $past(in_data));
  endproperty
  a_valid_follows_fill: assert property (p_valid_follows_fill)
    else $error("pushed word not presented");
endmodule
`default_nettype wire

/* design/asc_serial_ctrl.sv */
// Overview of operation
// RULE_01: control word bits 7, 6, 2, 1 and 0 have no effect.
// RULE_02: bits 5..3 choose the channel for the following conversion.
// RULE_03: address is a plain binary index; channel zero before any write.
// RULE_04: result is an unsigned straight-binary 10-bit code.
// RULE_05: powered while select low, powered down while select high.
// RULE_06: continuous mode powers down between falling edge 16 and next edge 1.
// RULE_07: each conversion is 16 clocks, back to back while select low.
// RULE_08: host may space conversions with select high to save power.
// RULE_09: frame spans select low, whole 16-edge multiples; output off when high.
// RULE_10: zeros on falls 1-4, result msb first on 5-14, zeros on 15-16.
// RULE_11: control word captured on the first 8 rising edges of a conversion.
// RULE_12: track for the first 3 cycles, hold and convert for 13.
// RULE_13: control word msb first; channel address persists until rewritten.
`timescale 1ns/1ps
`default_nettype none
`include "asc_params.svh"
module asc_serial_ctrl (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  output var  logic                 dout,
  output var  logic                 dout_oe,
  output var  logic                 powered,
  output var  logic                 tracking,
  output var  asc_pkg::asc_chan_t   track_channel,
  output var  logic                 sample_req,
  output var  asc_pkg::asc_chan_t   sample_channel,
  input  wire logic                 code_valid,
  output var  logic                 code_ready,
  input  wire asc_pkg::asc_sample_t code_data
);
  import asc_pkg::*;

  function automatic asc_chan_t chan_field(input logic [7:0] ctl);
    chan_field = ctl[`ASC_ADDR_MSB:`ASC_ADDR_LSB];
  endfunction

  function automatic logic out_bit(input logic [3:0] edge_no, input asc_code_t code);
    logic [3:0] idx;
    idx = `ASC_DATA_LAST - edge_no;
    out_bit = 1'b0;
    if (edge_no >= `ASC_DATA_FIRST && edge_no <= `ASC_DATA_LAST)
      out_bit = code[idx];
  endfunction

  logic        frame_rst_n;
  logic        sclk_n;
  logic [3:0]  rcnt;
  logic [7:0]  ctl_shift;
  asc_chan_t   chan_addr;
  logic [3:0]  fcnt;
  logic [3:0]  next_fcnt;
  asc_code_t   tx_code;
  logic        conv_tgl;
  logic        ack_tgl;
  logic        req_tgl_link;
  logic        conv_s;
  logic        conv_d;
  logic        ack_s;
  logic        req_tgl;
  asc_code_t   hold_code;
  asc_hs_state_t hs_state;
  logic        buf_valid;
  logic        buf_pop;
  asc_sample_t buf_data;
  logic        link_seen;

  assign frame_rst_n = rstn && !cs_n;
  assign sclk_n      = ~sclk;
  assign next_fcnt   = fcnt + 4'h1;

  // rising-edge side: control word capture
  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      rcnt      <= 4'h0;
      ctl_shift <= `ASC_CTL_RESET;
    end
    else
    begin
      rcnt <= rcnt + 4'h1; // see RULE_07
      if (rcnt < `ASC_CTL_BITS)
        ctl_shift <= {ctl_shift[6:0], din}; // see RULE_11 see RULE_13
    end
  end

  // channel address survives frames, cleared only by reset
  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
      chan_addr <= `ASC_CHAN_RESET; // see RULE_03
    else if (!cs_n && rcnt == `ASC_CTL_BITS - 4'h1)
      chan_addr <= chan_field({ctl_shift[6:0], din}); // see RULE_01 see RULE_13
  end

  // falling-edge side: edge count, power, track and output shifting
  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      fcnt     <= 4'h0;
      dout     <= 1'b0;
      dout_oe  <= 1'b0;
      powered  <= 1'b0;
      tracking <= 1'b0;
    end
    else
    begin
      fcnt     <= next_fcnt; // see RULE_07
      dout_oe  <= 1'b1; // see RULE_09
      dout     <= out_bit(next_fcnt, tx_code); // see RULE_10 see RULE_04
      powered  <= (next_fcnt != `ASC_EDGE_LAST); // see RULE_05 see RULE_06
      tracking <= (next_fcnt >= `ASC_EDGE_FIRST) && (next_fcnt <= `ASC_TRACK_LAST); // see RULE_12
    end
  end

  // channel of the conversion now starting, announced to the core side
  always_ff @(negedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      track_channel <= `ASC_CHAN_RESET;
      conv_tgl      <= 1'b0;
    end
    else if (!cs_n && next_fcnt == `ASC_EDGE_FIRST)
    begin
      track_channel <= chan_addr; // see RULE_02
      conv_tgl      <= ~conv_tgl;
    end
  end

  // marks that the link clock has ticked once since reset
  always_ff @(negedge sclk or negedge rstn)
  begin
    if (!rstn)
      link_seen <= 1'b0;
    else
      link_seen <= 1'b1;
  end

  // result word taken over at the start of hold
  always_ff @(negedge sclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_code <= `ASC_CODE_RESET;
      ack_tgl <= 1'b0;
    end
    else if (!cs_n && next_fcnt == `ASC_LOAD_EDGE && req_tgl_link != ack_tgl)
    begin
      tx_code <= hold_code; // see RULE_04
      ack_tgl <= ~ack_tgl;
    end
  end

  asc_sync2 u_req_sync (
    .clk   (sclk_n),
    .rst_n (rstn),
    .d     (req_tgl),
    .q     (req_tgl_link)
  );

  asc_sync2 u_conv_sync (
    .clk   (core_clk),
    .rst_n (rstn),
    .d     (conv_tgl),
    .q     (conv_s)
  );

  asc_sync2 u_ack_sync (
    .clk   (core_clk),
    .rst_n (rstn),
    .d     (ack_tgl),
    .q     (ack_s)
  );

  // core side: one pulse per conversion start
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_d         <= 1'b0;
      sample_req     <= 1'b0;
      sample_channel <= `ASC_CHAN_RESET;
    end
    else
    begin
      conv_d     <= conv_s;
      sample_req <= conv_s ^ conv_d;
      if (conv_s ^ conv_d)
        sample_channel <= track_channel; // see RULE_02
    end
  end

  asc_buf2 u_buf (
    .clk       (core_clk),
    .rst_n     (rstn),
    .in_valid  (code_valid),
    .in_ready  (code_ready),
    .in_data   (code_data),
    .out_valid (buf_valid),
    .out_ready (buf_pop),
    .out_data  (buf_data)
  );

  assign buf_pop = (hs_state == ASC_IDLE) && buf_valid;

  // core side: word handshake toward the link
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hs_state  <= ASC_IDLE;
      req_tgl   <= 1'b0;
      hold_code <= `ASC_CODE_RESET;
    end
    else
    begin
      case (hs_state)
        ASC_IDLE:
        begin
          if (buf_valid)
          begin
            hold_code <= buf_data.code; // see RULE_04
            req_tgl   <= ~req_tgl;
            hs_state  <= ASC_WAIT;
          end
        end
        ASC_WAIT:
        begin
          if (ack_s == req_tgl)
            hs_state <= ASC_IDLE;
        end
        default:
          hs_state <= ASC_IDLE;
      endcase
    end
  end

  property p_lead_trail_zero;
    @(negedge sclk) disable iff (!frame_rst_n)
    ((fcnt >= 4'h1 && fcnt <= 4'h4) || fcnt == 4'hF || fcnt == 4'h0) |-> !dout;
  endproperty
  a_lead_trail_zero: assert property (p_lead_trail_zero) // see RULE_10
    else $error("nonzero bit outside data slot");

  property p_data_msb_first;
    @(negedge sclk) disable iff (!frame_rst_n)
    (fcnt >= 4'h5 && fcnt <= 4'hE) |-> (dout == tx_code[4'hE - fcnt]);
  endproperty
  a_data_msb_first: assert property (p_data_msb_first) // see RULE_10
    else $error("data bit out of order");

  property p_track_window;
    @(negedge sclk) disable iff (!frame_rst_n)
    (fcnt == 4'h1) |-> tracking ##1 tracking ##1 tracking ##1 !tracking;
  endproperty
  a_track_window: assert property (p_track_window) // see RULE_12
    else $error("track window not three cycles");

  property p_gap_down;
    @(negedge sclk) disable iff (!frame_rst_n)
    (fcnt == 4'h0) |-> !powered;
  endproperty
  a_gap_down: assert property (p_gap_down) // see RULE_06
    else $error("powered in conversion gap");

  property p_conv_up;
    @(negedge sclk) disable iff (!frame_rst_n)
    (fcnt != 4'h0) |-> powered && dout_oe;
  endproperty
  a_conv_up: assert property (p_conv_up) // see RULE_05
    else $error("not powered inside conversion");

  property p_addr_capture;
    @(posedge sclk) disable iff (!frame_rst_n)
    (rcnt == 4'h8) |-> (chan_addr == ctl_shift[5:3]);
  endproperty
  a_addr_capture: assert property (p_addr_capture) // see RULE_13
    else $error("channel address not taken from bits 5..3");

  property p_ctl_msb_first;
    @(posedge sclk) disable iff (!frame_rst_n)
    (rcnt < 4'h8) |=> (ctl_shift[0] == $past(din));
  endproperty
  a_ctl_msb_first: assert property (p_ctl_msb_first) // see RULE_11
    else $error("control bit not shifted in at its edge");

  property p_chan_next_conv;
    @(negedge sclk) disable iff (!frame_rst_n)
    link_seen && (fcnt != 4'h1) |-> $stable(track_channel);
  endproperty
  a_chan_next_conv: assert property (p_chan_next_conv) // see RULE_02
    else $error("channel changed mid conversion");

  property p_req_pulse;
    @(posedge core_clk) disable iff (!rstn)
    sample_req |=> !sample_req;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("sample request longer than one cycle");

  property p_hs_hold;
    @(posedge core_clk) disable iff (!rstn)
    (hs_state == ASC_WAIT) && (ack_s != req_tgl) |=> $stable(hold_code);
  endproperty
  a_hs_hold: assert property (p_hs_hold)
    else $error("hold word changed while link may read it");
endmodule
`default_nettype wire

/* testbench/asc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module asc_host (
  output var  logic               sclk,
  output var  logic               cs_n,
  output var  logic               din,
  input  wire logic               dout,
  input  wire logic               dout_oe,
  input  wire logic               tracking,
  input  wire logic               powered,
  input  wire asc_pkg::asc_chan_t track_channel
);
  import asc_pkg::*;
  logic      [7:0]  ctl [0:15];
  logic      [15:0] rx  [0:15];
  logic      [1:0]  trk [0:15];
  logic      [1:0]  pw  [0:15];
  asc_chan_t        ch  [0:15];
  logic             filler = 1'b0;
  wire logic        line = dout_oe ? dout : filler;
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // released output shows a changing pattern
  always #37 filler = ~filler;
  task automatic frame(input int n, input int base);
    int k;
    int e;
    #13;
    cs_n = 1'b0;
    #40;
    for (k = base; k < base + n; k++)
    begin
      for (e = 1; e <= 16; e++)
      begin
        sclk = 1'b0;
        #5;
        din = (e <= 8) ? ctl[k][8-e] : 1'b0;
        #35;
        sclk = 1'b1;
        rx[k][16-e] = line;
        if (e == 1) ch[k] = track_channel;
        if (e == 3) trk[k][1] = tracking;
        if (e == 4) trk[k][0] = tracking;
        if (e == 8) pw[k][1] = powered;
        if (e == 16) pw[k][0] = powered;
        #40;
      end
    end
    cs_n = 1'b1;
    // idle gap between bursts
    #400;
  endtask
endmodule
`default_nettype wire

/* testbench/adc_serial_channel_power_ctrl_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_serial_channel_power_ctrl_test;
  import asc_pkg::*;
  logic        core_clk   = 1'b0;
  logic        rstn;
  logic        code_valid = 1'b0;
  asc_sample_t code_data  = '0;
  wire logic   sclk, cs_n, din, dout, dout_oe, powered, tracking, code_ready, sample_req;
  wire asc_chan_t track_channel, sample_channel;
  int          miscompares = 0;
  int          n_tests     = 0;
  int          cyc         = 0;
  int          n_req       = 0;
  logic [9:0]  codes [0:2] = '{10'h3FF, 10'h000, 10'h2A5};
  always #25 core_clk = ~core_clk;
  asc_serial_ctrl u_dut (
    .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .powered(powered), .tracking(tracking),
    .track_channel(track_channel), .sample_req(sample_req),
    .sample_channel(sample_channel), .code_valid(code_valid),
    .code_ready(code_ready), .code_data(code_data)
  );
  asc_host u_host (
    .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
    .tracking(tracking), .powered(powered), .track_channel(track_channel)
  );
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (sample_req === 1'b1) n_req <= n_req + 1;
    if (cyc == 4000)
    begin
      miscompares++;
      results();
    end
  end
  task automatic push(input logic [9:0] c);
    int w;
    @(posedge core_clk);
    code_valid <= 1'b1;
    code_data  <= '{channel: 3'h0, code: c};
    w = 0;
    do
    begin
      @(posedge core_clk);
      w++;
    end
    while (code_ready !== 1'b1 && w < 50);
    code_valid <= 1'b0;
    check("code accepted", 16'(w < 50), 16'h0001);
  endtask
  task automatic t_idle;
    check("dout_oe idle", 16'(dout_oe), 16'h0000);
    check("powered idle", 16'(powered), 16'h0000);
  endtask
  // three words fill hold word and both buffer entries
  task automatic t_fill;
    for (int i = 0; i < 3; i++) push(codes[i]);
    repeat (4) @(posedge core_clk);
    check("code_ready full", 16'(code_ready), 16'h0000);
  endtask
  task automatic t_stream;
    logic [2:0] a;
    for (int k = 0; k < 9; k++) u_host.ctl[k] = {2'(k), 3'(k + 3), ~3'(k)};
    u_host.frame(9, 0);
    for (int k = 0; k < 9; k++)
    begin
      a = (k == 0) ? 3'h0 : 3'(k + 2);
      check("channel", 16'(u_host.ch[k]), 16'(a));
      check("dout word", u_host.rx[k], {4'h0, codes[k > 2 ? 2 : k], 2'b00});
      check("tracking", 16'(u_host.trk[k]), 16'h0002);
      check("power gap", 16'(u_host.pw[k]), 16'h0002);
    end
    check("powered after frame", 16'(powered), 16'h0000);
    check("dout_oe after frame", 16'(dout_oe), 16'h0000);
  endtask
  task automatic t_burst;
    u_host.ctl[9] = 8'h00;
    u_host.frame(1, 9);
    check("channel kept", 16'(u_host.ch[9]), 16'h0003);
    check("word repeats", u_host.rx[9], {4'h0, codes[2], 2'b00});
    check("conversions", 16'(n_req), 16'h000A);
    check("sample channel", 16'(sample_channel), 16'h0003);
  endtask
  initial
  begin
    rstn <= 1'b0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_idle();
    t_fill();
    t_stream();
    t_burst();
    results();
  end
endmodule
`default_nettype wire
